// *** core/ims_ctrl.sv ***
// two-wire bus controller with concurrent master and slave functions
`timescale 1ns/1ps
`include "ims_consts.svh"
module ims_ctrl
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            scl_out,
   output logic            scl_oe,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       m_go,
   input  wire logic       m_start,
   input  wire logic       m_stop,
   input  wire logic [6:0] m_addr,
   input  wire logic       m_rw,
   input  wire logic [7:0] m_wdata,
   input  wire logic [7:0] m_tpr,
   output logic            m_busy,
   output logic [7:0]      m_rdata,
   output logic            m_error,
   output logic            m_arb_lost,
   output logic            m_irq,
   output logic            bus_busy,
   input  wire logic       s_enable,
   input  wire logic [6:0] s_own_addr,
   input  wire logic       s_tx_load,
   input  wire logic [7:0] s_wdata,
   output logic [7:0]      s_rdata,
   output logic            s_rx_valid,
   output logic            s_first,
   output logic            s_tx_req,
   output logic            s_irq
);
   //---------------------------------------------
   // declarations
   //---------------------------------------------
   logic             scl_m_r, scl_s_r, scl_d_r;
   logic             sda_m_r, sda_s_r, sda_d_r;
   logic             start_det, stop_det, scl_rise, scl_fall;
   logic             bus_ok;
   ims_pkg::ims_mst_t m_st_r;
   logic [8:0]       pre_r;
   logic [3:0]       ph_r;
   logic [3:0]       mb_r;
   logic [7:0]       msh_r;
   logic             run, freeze, tick, tx_bit, sda_upd;
   logic             own_r, addr_ph_r, rw_r, stop_r;
   logic             samp_r, nack_r;
   logic             m_sda_want, m_sda_low_r, m_scl_low;
   ims_pkg::ims_slv_t s_st_r;
   logic [7:0]       ssh_r;
   logic [3:0]       sb_r;
   logic             s_ack_r, s_rw_r, s_nack_r, s_fpend_r;
   logic             s_sda_low, s_scl_low;
   logic             s_lead_r;

   //---------------------------------------------
   // line synchronisers and condition detect
   //---------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
         {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      end
      else
      begin
         {scl_m_r, scl_s_r, scl_d_r} <= {scl_in, scl_m_r, scl_s_r};
         {sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
      end
   end

   // clock must be high on both samples so a data edge near scl edges
   // is not mistaken for a condition
   assign start_det = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
   assign stop_det  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
   assign scl_rise  = scl_s_r & ~scl_d_r;
   assign scl_fall  = ~scl_s_r & scl_d_r;
   assign bus_ok    = ~bus_busy & scl_s_r & sda_s_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         bus_busy <= 1'b0;
      else if (start_det)
         bus_busy <= 1'b1;
      else if (stop_det)
         bus_busy <= 1'b0;
   end

   //---------------------------------------------
   // master clock generator
   //---------------------------------------------
   assign run = (m_st_r == ims_pkg::M_START) ||
                (m_st_r == ims_pkg::M_BYTE) ||
                (m_st_r == ims_pkg::M_STOP);
   // high phase waits for the released line: stretching by a slave or
   // a slower master simply extends the unit
   assign freeze = (ph_r >= `IMS_LOW_UNITS && !scl_s_r) ||
                   (m_st_r == ims_pkg::M_START && !own_r &&
                    ph_r < `IMS_SAMPLE_PH && !bus_ok);
   assign tick = run && !freeze && (pre_r == {m_tpr, 1'b1});

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         pre_r <= 9'h000;
      else if (!run || tick)
         pre_r <= 9'h000;
      else if (!freeze)
         pre_r <= pre_r + 9'h001;
   end

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         ph_r <= 4'h0;
      else if (!run)
         ph_r <= 4'h0;
      else if (tick)
         ph_r <= (ph_r == `IMS_PHASE_LAST) ? 4'h0 : ph_r + 4'h1;
   end

   //---------------------------------------------
   // master sequencer
   //---------------------------------------------
   assign tx_bit = addr_ph_r | ~rw_r;

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         m_st_r     <= ims_pkg::M_IDLE;
         mb_r       <= 4'h0;
         msh_r      <= 8'h00;
         own_r      <= 1'b0;
         addr_ph_r  <= 1'b0;
         rw_r       <= 1'b0;
         stop_r     <= 1'b0;
         samp_r     <= 1'b0;
         nack_r     <= 1'b0;
         m_busy     <= 1'b0;
         m_rdata    <= 8'h00;
         m_error    <= 1'b0;
         m_arb_lost <= 1'b0;
         m_irq      <= 1'b0;
      end
      else
      begin
         m_irq <= 1'b0;
         case (m_st_r)
            ims_pkg::M_IDLE, ims_pkg::M_HOLD:
            begin
               if (!own_r)
                  m_st_r <= ims_pkg::M_IDLE;
               if (m_go && (m_start || own_r))
               begin
                  m_busy     <= 1'b1;
                  m_error    <= 1'b0;
                  m_arb_lost <= 1'b0;
                  stop_r     <= m_stop;
                  mb_r       <= 4'h0;
                  if (m_start)
                  begin
                     // repeated start keeps ownership
                     m_st_r    <= ims_pkg::M_START;
                     addr_ph_r <= 1'b1;
                     rw_r      <= m_rw;
                     msh_r     <= {m_addr, m_rw};
                  end
                  else
                  begin
                     m_st_r    <= ims_pkg::M_BYTE;
                     addr_ph_r <= 1'b0;
                     msh_r     <= m_wdata;
                  end
               end
            end
            ims_pkg::M_START:
            begin
               if (tick && ph_r == `IMS_SAMPLE_PH - 4'h1)
                  own_r <= 1'b1;
               if (tick && ph_r == `IMS_PHASE_LAST)
                  m_st_r <= ims_pkg::M_BYTE;
            end
            ims_pkg::M_BYTE:
            begin
               if (tick && ph_r == `IMS_SAMPLE_PH)
               begin
                  samp_r <= sda_s_r;
                  if (mb_r == `IMS_ACK_BIT)
                     nack_r <= sda_s_r;
                  else if (tx_bit && msh_r[7] && !sda_s_r)
                  begin
                     m_st_r     <= ims_pkg::M_ARB;
                     m_arb_lost <= 1'b1;
                     m_error    <= 1'b1;
                     own_r      <= 1'b0;
                  end
               end
               if (tick && ph_r == `IMS_PHASE_LAST)
               begin
                  if (mb_r != `IMS_ACK_BIT)
                  begin
                     msh_r <= {msh_r[6:0], samp_r};
                     mb_r  <= mb_r + 4'h1;
                  end
                  else if (tx_bit && nack_r)
                  begin
                     m_st_r  <= ims_pkg::M_STOP;
                     m_error <= 1'b1;
                  end
                  else if (addr_ph_r)
                  begin
                     addr_ph_r <= 1'b0;
                     mb_r      <= 4'h0;
                     msh_r     <= m_wdata;
                  end
                  else
                  begin
                     m_rdata <= msh_r;
                     if (stop_r)
                        m_st_r <= ims_pkg::M_STOP;
                     else
                     begin
                        m_st_r <= ims_pkg::M_HOLD;
                        m_busy <= 1'b0;
                        m_irq  <= 1'b1;
                     end
                  end
               end
            end
            ims_pkg::M_STOP:
            begin
               if (tick && ph_r == `IMS_PHASE_LAST)
               begin
                  m_st_r <= ims_pkg::M_IDLE;
                  own_r  <= 1'b0;
                  m_busy <= 1'b0;
                  m_irq  <= 1'b1;
               end
            end
            ims_pkg::M_ARB:
            begin
               if (!bus_busy)
               begin
                  m_st_r <= ims_pkg::M_IDLE;
                  m_busy <= 1'b0;
                  m_irq  <= 1'b1;
               end
            end
            default:
               m_st_r <= ims_pkg::M_IDLE;
         endcase
      end
   end

   //---------------------------------------------
   // master line drive
   //---------------------------------------------
   always_comb
   begin
      m_sda_want = 1'b0;
      m_scl_low  = 1'b0;
      case (m_st_r)
         ims_pkg::M_START:
         begin
            m_sda_want = (ph_r >= `IMS_SAMPLE_PH);
            m_scl_low  = own_r && (ph_r < `IMS_LOW_UNITS);
         end
         ims_pkg::M_BYTE:
         begin
            if (mb_r == `IMS_ACK_BIT)
               m_sda_want = ~tx_bit & ~stop_r;
            else
               m_sda_want = tx_bit & ~msh_r[7];
            m_scl_low = (ph_r < `IMS_LOW_UNITS);
         end
         ims_pkg::M_STOP:
         begin
            m_sda_want = (ph_r < `IMS_SAMPLE_PH);
            m_scl_low  = (ph_r < `IMS_LOW_UNITS);
         end
         ims_pkg::M_HOLD:
            m_scl_low = 1'b1;
         default:
            m_scl_low = 1'b0;
      endcase
   end

   // data may move only mid-low, at the start and stop edges, or while the sequencer is not running;
   // gives clear margin after the registered scl fall
   assign sda_upd = !run ||
                    (ph_r >= `IMS_DRIVE_FIRST && ph_r <= `IMS_DRIVE_LAST) ||
                    (ph_r >= `IMS_SAMPLE_PH && m_st_r != ims_pkg::M_BYTE);

   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
         m_sda_low_r <= 1'b0;
      else if (sda_upd)
         m_sda_low_r <= m_sda_want;
   end

   //---------------------------------------------
   // slave
   //---------------------------------------------
   assign s_sda_low = ((s_st_r == ims_pkg::S_ADDR ||
                        s_st_r == ims_pkg::S_RX) &&
                       sb_r == `IMS_ACK_BIT && s_ack_r) ||
                      (s_st_r == ims_pkg::S_TX &&
                       sb_r != `IMS_ACK_BIT && ~ssh_r[7]);
   // clock held one cycle past the load so the first bit settles first
   assign s_scl_low = (s_st_r == ims_pkg::S_TXWAIT) || s_lead_r;

   // slave runs from bus samples only, never from master state
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s_st_r     <= ims_pkg::S_IDLE;
         ssh_r      <= 8'h00;
         sb_r       <= 4'h0;
         s_ack_r    <= 1'b0;
         s_rw_r     <= 1'b0;
         s_nack_r   <= 1'b0;
         s_fpend_r  <= 1'b0;
         s_lead_r   <= 1'b0;
         s_rdata    <= 8'h00;
         s_rx_valid <= 1'b0;
         s_first    <= 1'b0;
         s_tx_req   <= 1'b0;
         s_irq      <= 1'b0;
      end
      else
      begin
         s_rx_valid <= 1'b0;
         s_tx_req   <= 1'b0;
         s_irq      <= 1'b0;
         s_lead_r   <= 1'b0;
         if (start_det)
         begin
            s_st_r  <= s_enable ? ims_pkg::S_ADDR : ims_pkg::S_IDLE;
            // the clock fall after a start opens bit 7, so count from -1
            sb_r    <= 4'hf;
            s_ack_r <= 1'b0;
         end
         else if (stop_det)
         begin
            s_st_r  <= ims_pkg::S_IDLE;
            s_ack_r <= 1'b0;
         end
         else
         begin
            case (s_st_r)
               ims_pkg::S_ADDR, ims_pkg::S_RX:
               begin
                  if (scl_rise && sb_r != `IMS_ACK_BIT)
                     ssh_r <= {ssh_r[6:0], sda_s_r};
                  if (scl_fall)
                  begin
                     if (sb_r == `IMS_LAST_DATA)
                     begin
                        sb_r <= `IMS_ACK_BIT;
                        if (s_st_r == ims_pkg::S_ADDR)
                        begin
                           s_ack_r <= (ssh_r[7:1] == s_own_addr);
                           s_rw_r  <= ssh_r[0];
                        end
                        else
                        begin
                           s_ack_r    <= 1'b1;
                           s_rdata    <= ssh_r;
                           s_rx_valid <= 1'b1;
                           s_first    <= s_fpend_r;
                           s_fpend_r  <= 1'b0;
                           s_irq      <= 1'b1;
                        end
                     end
                     else if (sb_r == `IMS_ACK_BIT)
                     begin
                        sb_r    <= 4'h0;
                        s_ack_r <= 1'b0;
                        if (s_st_r == ims_pkg::S_RX)
                           s_st_r <= ims_pkg::S_RX;
                        else if (!s_ack_r)
                           s_st_r <= ims_pkg::S_IDLE;
                        else if (s_rw_r)
                        begin
                           s_st_r   <= ims_pkg::S_TXWAIT;
                           s_tx_req <= 1'b1;
                           s_irq    <= 1'b1;
                        end
                        else
                        begin
                           s_st_r    <= ims_pkg::S_RX;
                           s_fpend_r <= 1'b1;
                        end
                     end
                     else
                        sb_r <= sb_r + 4'h1;
                  end
               end
               ims_pkg::S_TXWAIT:
               begin
                  // clock held low until software supplies a byte
                  if (s_tx_load)
                  begin
                     ssh_r  <= s_wdata;
                     sb_r   <= 4'h0;
                     s_st_r <= ims_pkg::S_TX;
                     s_lead_r <= 1'b1;
                  end
               end
               ims_pkg::S_TX:
               begin
                  if (scl_rise && sb_r == `IMS_ACK_BIT)
                     s_nack_r <= sda_s_r;
                  if (scl_fall)
                  begin
                     if (sb_r == `IMS_ACK_BIT)
                     begin
                        sb_r <= 4'h0;
                        if (s_nack_r)
                           s_st_r <= ims_pkg::S_IDLE;
                        else
                        begin
                           s_st_r   <= ims_pkg::S_TXWAIT;
                           s_tx_req <= 1'b1;
                           s_irq    <= 1'b1;
                        end
                     end
                     else
                     begin
                        ssh_r <= {ssh_r[6:0], 1'b1};
                        sb_r  <= sb_r + 4'h1;
                     end
                  end
               end
               default:
                  s_st_r <= ims_pkg::S_IDLE;
            endcase
         end
      end
   end

   //---------------------------------------------
   // pads: open drain, low only
   //---------------------------------------------
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         scl_oe  <= 1'b0;
         sda_oe  <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         scl_oe  <= m_scl_low | s_scl_low;
         sda_oe  <= m_sda_low_r | s_sda_low;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   //---------------------------------------------
   // assertions
   //---------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   a_busy_set: assert property (start_det |=> bus_busy)
      else $error("busy not set after start");
   a_busy_clr: assert property (stop_det |=> !bus_busy)
      else $error("busy not cleared after stop");
   a_start_idle: assert property ((m_st_r == ims_pkg::M_START &&
      !own_r && tick && ph_r == 4'd7) |-> bus_ok)
      else $error("start issued on busy bus");
   a_arb_release: assert property ((m_st_r == ims_pkg::M_ARB)
      |=> !m_sda_low_r && !own_r)
      else $error("data still driven after lost arbitration");
   a_sda_window: assert property (($changed(m_sda_low_r) &&
      $past(m_st_r) == ims_pkg::M_BYTE) |->
      ($past(ph_r) >= 4'd2 && $past(ph_r) <= 4'd5))
      else $error("data moved outside low phase");
   a_unit_bound: assert property (pre_r <= {m_tpr, 1'b1})
      else $error("unit counter overran");
   a_ph_wrap: assert property ((tick && ph_r == 4'd9) |=> ph_r == 4'd0)
      else $error("phase did not wrap after ten units");
   a_nack_stop: assert property ((m_st_r == ims_pkg::M_BYTE &&
      tick && ph_r == 4'd9 && mb_r == 4'd8 && tx_bit && nack_r)
      |=> (m_st_r == ims_pkg::M_STOP && m_error))
      else $error("nack did not lead to stop with error");
   a_stop_irq: assert property ((m_st_r == ims_pkg::M_STOP &&
      tick && ph_r == 4'd9) |=> (m_irq && !m_busy) ##1 !m_irq)
      else $error("no single irq pulse after stop");
   a_slave_nomatch: assert property ((s_st_r == ims_pkg::S_ADDR &&
      scl_fall && sb_r == 4'd7 && ssh_r[7:1] != s_own_addr &&
      !start_det && !stop_det) |=> !s_ack_r)
      else $error("slave acked foreign address");
   a_slave_stretch: assert property ((s_st_r == ims_pkg::S_TXWAIT)
      |=> scl_oe)
      else $error("slave not holding clock while waiting");
   a_rx_irq: assert property ($rose(s_rx_valid) |-> s_irq)
      else $error("slave receive without irq");

   c_master_done: cover property (m_irq && !m_error);
   c_arb_lost: cover property (m_irq && m_arb_lost);
   c_slave_rx: cover property (s_rx_valid && s_first);
   c_slave_tx: cover property (s_tx_req ##[1:1000] s_tx_load);
endmodule

// *** inc/ims_consts.svh ***
// timing and bit-slot constants for the two-wire controller
`ifndef IMS_CONSTS_SVH
`define IMS_CONSTS_SVH
`define IMS_LOW_UNITS    4'd6
`define IMS_HIGH_UNITS   4'd4
`define IMS_PHASE_LAST   (`IMS_LOW_UNITS + `IMS_HIGH_UNITS - 4'd1)
`define IMS_DRIVE_FIRST  4'd2
`define IMS_DRIVE_LAST   4'd5
`define IMS_SAMPLE_PH    4'd8
`define IMS_ACK_BIT      4'd8
`define IMS_LAST_DATA    4'd7
`define IMS_TPR_STD      8'h7c
`define IMS_TPR_FAST     8'h1f
`endif

// *** inc/ims_pkg.sv ***
// state types of the two-wire controller
package ims_pkg;
   typedef enum logic [2:0]
   {
      M_IDLE  = 3'b000,
      M_START = 3'b001,
      M_BYTE  = 3'b010,
      M_HOLD  = 3'b011,
      M_STOP  = 3'b100,
      M_ARB   = 3'b101
   } ims_mst_t;
   typedef enum logic [2:0]
   {
      S_IDLE   = 3'b000,
      S_ADDR   = 3'b001,
      S_RX     = 3'b010,
      S_TXWAIT = 3'b011,
      S_TX     = 3'b100
   } ims_slv_t;
endpackage

// *** testbench/ims_slave_model.sv ***
// behavioural far-side slave device on the two-wire bus
`timescale 1ns/1ps
module ims_slave_model
#(
   parameter logic [6:0] ADDR = 7'h3b
)
(
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic [7:0] tx_byte,
   output logic            sda_lo,
   output logic [7:0]      rx_byte
);
   logic [7:0] b;
   // ----------------------------------------
   // byte engine
   // ----------------------------------------
   task automatic get_byte();
      repeat (8)
      begin
         @(posedge scl);
         b = {b[6:0], sda};
      end
   endtask
   // release well after the fall, never while clock high
   task automatic ack();
      @(negedge scl);
      #4 sda_lo = 1'b1;
      @(negedge scl);
      #4 sda_lo = 1'b0;
   endtask
   initial
   begin
      sda_lo = 1'b0;
      rx_byte = 8'h00;
      forever
      begin
         @(negedge sda iff scl === 1'b1);
         get_byte();
         if (b[7:1] === ADDR)
         begin
            ack();
            if (b[0])
            begin
               for (int i = 7; i >= 0; i--)
               begin
                  sda_lo = ~tx_byte[i];
                  @(negedge scl);
                  #4;
               end
               sda_lo = 1'b0;
            end
            else
            begin
               get_byte();
               rx_byte = b;
               ack();
            end
         end
      end
   end
endmodule

// *** testbench/ims_ctrl_bench.sv ***
// self-checking bench for the two-wire controller
`timescale 1ns/1ps
module ims_ctrl_bench;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   logic       bm_scl_lo = 1'b0;
   logic       bm_sda_lo = 1'b0;
   logic       m_go = 1'b0;
   logic       m_start = 1'b0;
   logic       m_stop = 1'b0;
   logic       m_rw = 1'b0;
   logic [6:0] m_addr = 7'h00;
   logic [7:0] m_wdata = 8'h00;
   logic       scl_oe, sda_oe, sl_sda_lo, m_busy, m_error, m_arb_lost;
   logic       m_irq, bus_busy, s_rx_valid, s_first;
   logic [7:0] m_rdata, s_rdata, sl_rx;
   logic [7:0] got_rx = 8'h00;
   logic       got_first = 1'b0;
   logic       s_tx_load = 1'b0;
   logic [7:0] s_wdata = 8'h00;
   logic       s_tx_req, s_irq;
   logic       got_req_irq = 1'b0;
   int         n_req = 0;
   int         bad_count = 0;
   int         n_checks = 0;
   // open-drain lines with pull-ups
   wire        scl = ~(scl_oe | bm_scl_lo);
   wire        sda = ~(sda_oe | sl_sda_lo | bm_sda_lo);
   // ----------------------------------------
   // instances
   // ----------------------------------------
   ims_ctrl ims_ctrl_inst
   (
      .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
      .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe),
      .m_go(m_go), .m_start(m_start), .m_stop(m_stop), .m_addr(m_addr),
      .m_rw(m_rw), .m_wdata(m_wdata), .m_tpr(8'h01), .m_busy(m_busy),
      .m_rdata(m_rdata), .m_error(m_error), .m_arb_lost(m_arb_lost),
      .m_irq(m_irq), .bus_busy(bus_busy), .s_enable(1'b1),
      .s_own_addr(7'h51), .s_tx_load(s_tx_load), .s_wdata(s_wdata),
      .s_rdata(s_rdata), .s_rx_valid(s_rx_valid), .s_first(s_first),
      .s_tx_req(s_tx_req), .s_irq(s_irq)
   );
   ims_slave_model ims_slave_model_inst
   (
      .scl(scl), .sda(sda), .tx_byte(8'h3c), .sda_lo(sl_sda_lo),
      .rx_byte(sl_rx)
   );
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   always #2 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
   begin
      if (s_rx_valid === 1'b1)
      begin
         got_rx = s_rdata;
         got_first = s_first;
      end
      if (s_tx_req === 1'b1)
      begin
         n_req++;
         got_req_irq = s_irq;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic m_run(input logic [6:0] a, input logic rw,
                        input logic [7:0] d);
      int k;
      @(negedge clk_sys);
      m_go = 1'b1;
      m_start = 1'b1;
      m_stop = 1'b1;
      m_addr = a;
      m_rw = rw;
      m_wdata = d;
      @(negedge clk_sys);
      m_go = 1'b0;
      check({7'h00, m_busy}, 8'h01);
      k = 0;
      while (m_irq !== 1'b1 && k < 3000)
      begin
         @(negedge clk_sys);
         k++;
      end
      check({6'h00, m_irq, m_busy}, 8'h02);
   endtask
   // link clock of 48 ns, edges on the falling system clock edges
   task automatic bm_bit(input logic v);
      bm_sda_lo = ~v;
      #12 bm_scl_lo = 1'b0;
      #24 bm_scl_lo = 1'b1;
      #12;
   endtask
   task automatic bm_byte(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         bm_bit(v[i]);
      bm_sda_lo = 1'b0;
      #12 bm_scl_lo = 1'b0;
      #20 check({7'h00, sda}, 8'h00);
      #4 bm_scl_lo = 1'b1;
      #12;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_write();
      m_run(7'h3b, 1'b0, 8'ha5);
      check({6'h00, m_error, m_arb_lost}, 8'h00);
      check(sl_rx, 8'ha5);
      check({7'h00, bus_busy}, 8'h00);
   endtask
   task automatic t_read();
      m_run(7'h3b, 1'b1, 8'h00);
      check(m_rdata, 8'h3c);
   endtask
   task automatic t_nack();
      m_run(7'h12, 1'b0, 8'h77);
      check({6'h00, m_error, m_arb_lost}, 8'h02);
   endtask
   task automatic t_slave_rx();
      @(negedge clk_sys);
      bm_sda_lo = 1'b1;
      #24 bm_scl_lo = 1'b1;
      #12 check({7'h00, bus_busy}, 8'h01);
      bm_byte({7'h51, 1'b0});
      bm_byte(8'hc3);
      bm_sda_lo = 1'b1;
      #12 bm_scl_lo = 1'b0;
      #12 bm_sda_lo = 1'b0;
      #40 check(got_rx, 8'hc3);
      check({7'h00, got_first}, 8'h01);
      check({7'h00, bus_busy}, 8'h00);
   endtask
   // bench reads one byte from the device slave, which stretches first
   task automatic t_slave_tx();
      logic [7:0] v;
      v = 8'h00;
      @(negedge clk_sys);
      bm_sda_lo = 1'b1;
      #24 bm_scl_lo = 1'b1;
      #12 bm_byte({7'h51, 1'b1});
      #12 bm_scl_lo = 1'b0;
      #24 check({7'h00, scl}, 8'h00);
      check({7'h00, got_req_irq}, 8'h01);
      @(negedge clk_sys);
      s_tx_load = 1'b1;
      s_wdata = 8'h69;
      @(negedge clk_sys);
      s_tx_load = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         wait (scl === 1'b1);
         @(negedge clk_sys);
         #16 v[i] = sda;
         #4 bm_scl_lo = 1'b1;
         #24 bm_scl_lo = 1'b0;
      end
      wait (scl === 1'b1);
      @(negedge clk_sys);
      #16 check({7'h00, sda}, 8'h01);
      #4 bm_scl_lo = 1'b1;
      #24 bm_sda_lo = 1'b1;
      #12 bm_scl_lo = 1'b0;
      #12 bm_sda_lo = 1'b0;
      #40 check(v, 8'h69);
      check(n_req[7:0], 8'h01);
      check({7'h00, bus_busy}, 8'h00);
   endtask
   initial
   begin
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      repeat (6) @(negedge clk_sys);
      t_write();
      t_read();
      t_nack();
      t_slave_rx();
      t_slave_tx();
      stop_test();
   end
   initial
   begin
      #100000;
      bad_count++;
      stop_test();
   end
endmodule
